// ---- design/pmc_power_mgmt_regs.sv ----
// power management configuration registers, failure flags and input routing
// assumes same-clock inputs for sys_state, strobes and event status pulses;
// all pin inputs are asynchronous and pass two flip-flops
`timescale 1ns/1ps
module pmc_power_mgmt_regs #(
  parameter logic [15:0] GPI_IMPL   = 16'hFFFF,
  parameter int          RTC_DIV    = pmc_pkg::PMC_RTC_DIV_CYC,
  parameter int          STEP_CYC   = pmc_pkg::PMC_STEP_CYC,
  parameter int          SWSMI_BASE = pmc_pkg::PMC_SW_BASE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  input  wire logic        cpu_core_volt_good,
  input  wire logic        main_power_good,
  input  wire logic        resume_well_reset_n,
  input  wire logic        battery_well_reset_n,
  input  wire logic        trickle_supply_ok,
  input  wire logic        proc_sleep_n,
  input  wire logic        cpu_core_volt_good_exempt,
  input  wire logic [2:0]  sys_state,
  input  wire logic        reset_ctl_write,
  input  wire logic        stop_clock_req,
  input  wire logic        sw_timer_start,
  input  wire logic [15:0] input_event_status,
  input  wire logic [15:0] gpio_is_input,
  input  wire logic [15:0] general_event_enable,
  input  wire logic [15:0] alternate_input_smi_enable,
  output logic             proc_stop_clock_n,
  output logic             sw_timer_timeout,
  output logic             resume_reboot,
  output logic             power_return,
  output logic      [2:0]  power_return_state,
  output logic             after_power_loss_policy,
  output logic      [15:0] input_smi_req,
  output logic      [15:0] input_sci_req,
  output logic      [15:0] input_wake_req
);
  localparam int RTC_W = $clog2(RTC_DIV);
  localparam int STP_W = $clog2(STEP_CYC + 1);
  localparam int SW_W  = $clog2(SWSMI_BASE);
  // refuse settings the counters cannot serve
  if (RTC_DIV < 2 || STEP_CYC < 1 || STEP_CYC > 4096 || SWSMI_BASE < 2) begin : g_chk
    $error("pmc_power_mgmt_regs: unsupported timing parameters");
  end
  typedef struct packed {
    logic [5:0]        s1;
    logic [5:0]        s2;
    logic              pg_d;
    logic              rs_rtc;
    logic [RTC_W-1:0]  rtc_cnt;
    logic              cpu_flr;
    logic              power_good_fail_flag;
    logic              policy;
    logic              trickle;
    logic              batt_rm;
    logic [1:0]        rate;
    logic [5:0]        stop_del;
    logic [31:0]       route;
    pmc_pkg::pmc_pl_t  pl;
    logic              was_s4;
    logic              reboot_now;
    logic              pwr_ret;
    logic [2:0]        ret_state;
    pmc_pkg::pmc_sc_t  sc;
    logic              stop_n;
    logic              sl_d;
    logic [STP_W-1:0]  step_cnt;
    logic [5:0]        del_cnt;
    logic              sw_run;
    logic [SW_W-1:0]   sw_pre;
    logic [7:0]        sw_cnt;
    logic              sw_to;
    logic [15:0]       smi;
    logic [15:0]       acpi_control_interrupt;
    logic [15:0]       wake;
    logic [31:0]       rdata;
  } pmc_state_t;
  pmc_state_t r;
  pmc_state_t n;
  logic       tick;
  logic       pg_fall;
  logic       wr_flr;
  logic       wr_cfg3;
  logic       wr_stop;
  logic       wr_route;
  logic [1:0] rt;
  // software timer limit per rate select
  function automatic logic [7:0] sw_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    sw_limit = pmc_pkg::PMC_SW_CNT0;
      2'h1:    sw_limit = pmc_pkg::PMC_SW_CNT1;
      2'h2:    sw_limit = pmc_pkg::PMC_SW_CNT2;
      default: sw_limit = pmc_pkg::PMC_SW_CNT3;
    endcase
  endfunction
  // rtc tick, power good fall detect and write strobes per register
  assign tick     = r.rtc_cnt == RTC_W'(RTC_DIV - 1);
  assign pg_fall  = r.pg_d & ~r.s2[pmc_pkg::PMC_SY_PG];
  assign wr_flr   = cfg_wr && cfg_addr == pmc_pkg::PMC_OFS_FLR && cfg_be[0];
  assign wr_cfg3  = cfg_wr && cfg_addr == pmc_pkg::PMC_OFS_CFG3 && cfg_be[0];
  assign wr_stop  = cfg_wr && cfg_addr == pmc_pkg::PMC_OFS_STOP && cfg_be[0];
  assign wr_route = cfg_wr && cfg_addr == pmc_pkg::PMC_OFS_ROUTE;
  // next state of the whole block
  always_comb begin
    n = r;
    n.s1 = {proc_sleep_n, trickle_supply_ok, battery_well_reset_n,
            resume_well_reset_n, main_power_good, cpu_core_volt_good};
    n.s2 = r.s1;
    n.pg_d = r.s2[pmc_pkg::PMC_SY_PG];
    n.sl_d = r.s2[pmc_pkg::PMC_SY_SL];
    n.reboot_now = 1'b0;
    n.pwr_ret = 1'b0;
    n.sw_to = 1'b0;
    n.rtc_cnt = tick ? '0 : r.rtc_cnt + 1'b1;
    rt = 2'h0;
    if (tick) n.rs_rtc = r.s2[pmc_pkg::PMC_SY_RS];
    // software writes first so hardware sets win
    if (wr_flr) begin
      if (cfg_wdata[pmc_pkg::PMC_FLR_MAIN_POWER_GOOD]) n.power_good_fail_flag = 1'b0;
      if (!cfg_wdata[pmc_pkg::PMC_FLR_CPU]) n.cpu_flr = 1'b0;
    end
    if (wr_cfg3) begin
      n.rate = cfg_wdata[pmc_pkg::PMC_CFG3_RATE +: 2];
      n.batt_rm = cfg_wdata[pmc_pkg::PMC_CFG3_BATT];
      if (cfg_wdata[pmc_pkg::PMC_CFG3_TRICKLE]) n.trickle = 1'b0;
      n.policy = cfg_wdata[pmc_pkg::PMC_CFG3_POLICY];
    end
    if (wr_stop) n.stop_del = cfg_wdata[5:0];
    // absent inputs keep no route bits
    for (int b = 0; b < 4; b++) begin
      if (wr_route && cfg_be[b]) begin
        for (int k = 0; k < 4; k++) begin
          if (GPI_IMPL[4*b+k]) n.route[8*b+2*k +: 2] = cfg_wdata[8*b+2*k +: 2];
        end
      end
    end
    // sampled volt good, exempt during transitions
    if (tick && !r.s2[pmc_pkg::PMC_SY_VG] && !cpu_core_volt_good_exempt) n.cpu_flr = 1'b1;
    if (sys_state == pmc_pkg::PMC_SYS_G3) n.power_good_fail_flag = 1'b0;
    // fall in S0 or S1-M sets
    if (pg_fall && (sys_state == pmc_pkg::PMC_SYS_S0 || sys_state == pmc_pkg::PMC_SYS_S1M))
      n.power_good_fail_flag = 1'b1;
    if (reset_ctl_write) n.policy = 1'b0;
    // battery-well reset sets status, clears trickle and policy
    if (tick && !r.s2[pmc_pkg::PMC_SY_BR]) begin
      n.batt_rm = 1'b1;
      n.trickle = 1'b0;
      n.policy = 1'b0;
    end
    if (!r.s2[pmc_pkg::PMC_SY_TF]) n.trickle = 1'b1;
    // power loss tracker
    case (r.pl)
      pmc_pkg::PMC_PL_IDLE: begin
        n.was_s4 = sys_state == pmc_pkg::PMC_SYS_S4;
        if (pg_fall) n.pl = pmc_pkg::PMC_PL_DOWN;
      end
      pmc_pkg::PMC_PL_DOWN: begin
        if (tick && !r.s2[pmc_pkg::PMC_SY_RS]) n.pl = pmc_pkg::PMC_PL_FULL;
        // return with resume reset high forces reboot
        else if (r.s2[pmc_pkg::PMC_SY_PG]) begin
          n.reboot_now = 1'b1;
          n.pl = pmc_pkg::PMC_PL_IDLE;
        end
      end
      pmc_pkg::PMC_PL_FULL: begin
        if (r.s2[pmc_pkg::PMC_SY_PG] && r.rs_rtc) begin
          n.pwr_ret = 1'b1;
          n.ret_state = !r.policy ? pmc_pkg::PMC_SYS_S0 :
                        r.was_s4 ? pmc_pkg::PMC_SYS_S4 : pmc_pkg::PMC_SYS_S5;
          n.pl = pmc_pkg::PMC_PL_IDLE;
        end
      end
      default: n.pl = pmc_pkg::PMC_PL_IDLE;
    endcase
    // stop clock sequencing
    case (r.sc)
      pmc_pkg::PMC_SC_RUN: begin
        n.stop_n = 1'b1;
        if (stop_clock_req) begin
          n.sc = pmc_pkg::PMC_SC_STOP;
          n.stop_n = 1'b0;
        end
      end
      pmc_pkg::PMC_SC_STOP: begin
        // sleep release starts the delay
        if (!stop_clock_req && r.s2[pmc_pkg::PMC_SY_SL] && !r.sl_d) begin
          n.sc = pmc_pkg::PMC_SC_WAIT;
          n.step_cnt = '0;
          n.del_cnt = r.stop_del;
        end
      end
      pmc_pkg::PMC_SC_WAIT: begin
        // field value steps of fixed length, one step for a zero field
        n.step_cnt = r.step_cnt + 1'b1;
        if (r.step_cnt == STP_W'(STEP_CYC - 1)) begin
          n.step_cnt = '0;
          n.del_cnt = r.del_cnt - 1'b1;
          if (r.del_cnt <= 6'h01) begin
            n.sc = pmc_pkg::PMC_SC_RUN;
            n.stop_n = 1'b1;
          end
        end
      end
      default: begin
        n.sc = pmc_pkg::PMC_SC_RUN;
        n.stop_n = 1'b1;
      end
    endcase
    if (sw_timer_start) begin
      n.sw_run = 1'b1;
      n.sw_pre = '0;
      n.sw_cnt = 8'h00;
    end else if (r.sw_run) begin
      n.sw_pre = r.sw_pre + 1'b1;
      if (r.sw_pre == SW_W'(SWSMI_BASE - 1)) begin
        n.sw_pre = '0;
        n.sw_cnt = r.sw_cnt + 1'b1;
        if (r.sw_cnt + 8'h01 == sw_limit(r.rate)) begin
          n.sw_to = 1'b1;
          n.sw_run = 1'b0;
        end
      end
    end
    for (int i = 0; i < 16; i++) begin
      rt = r.route[2*i +: 2];
      n.smi[i] = input_event_status[i] && gpio_is_input[i] && rt == pmc_pkg::PMC_ROUTE_SMI
                 && alternate_input_smi_enable[i];
      n.acpi_control_interrupt[i] = input_event_status[i] && gpio_is_input[i] && rt == pmc_pkg::PMC_ROUTE_SCI
                 && general_event_enable[i];
      n.wake[i] = input_event_status[i] && gpio_is_input[i] && general_event_enable[i]
                  && sys_state != pmc_pkg::PMC_SYS_S0 && sys_state != pmc_pkg::PMC_SYS_G3;
    end
    // register read port, unmapped reads zero
    if (cfg_rd) begin
      case (cfg_addr)
        pmc_pkg::PMC_OFS_FLR:   n.rdata = {30'h0, r.cpu_flr, r.power_good_fail_flag};
        pmc_pkg::PMC_OFS_CFG3:  n.rdata = {24'h0, r.rate, 3'h0, r.batt_rm, r.trickle, r.policy};
        pmc_pkg::PMC_OFS_STOP:  n.rdata = {26'h0, r.stop_del};
        pmc_pkg::PMC_OFS_ROUTE: n.rdata = r.route;
        default:                n.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.s1 <= 6'h3F;
      r.s2 <= 6'h3F;
      r.pg_d <= 1'b1;
      r.rs_rtc <= 1'b1;
      r.sl_d <= 1'b1;
      r.rate <= pmc_pkg::PMC_RATE_RST;
      r.stop_del <= pmc_pkg::PMC_STOP_RST;
      r.route <= pmc_pkg::PMC_ROUTE_RST;
      r.pl <= pmc_pkg::PMC_PL_IDLE;
      r.sc <= pmc_pkg::PMC_SC_RUN;
      r.stop_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign cfg_rdata               = r.rdata;
  assign proc_stop_clock_n       = r.stop_n;
  assign sw_timer_timeout        = r.sw_to;
  assign resume_reboot           = r.reboot_now;
  assign power_return            = r.pwr_ret;
  assign power_return_state      = r.ret_state;
  assign after_power_loss_policy = r.policy;
  assign input_smi_req           = r.smi;
  assign input_sci_req           = r.acpi_control_interrupt;
  assign input_wake_req          = r.wake;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_drop_return;
    r.pl == pmc_pkg::PMC_PL_DOWN && r.s2[pmc_pkg::PMC_SY_PG]
      && !(tick && !r.s2[pmc_pkg::PMC_SY_RS]);
  endsequence
  sequence s_one_pulse;
    r.reboot_now ##1 !r.reboot_now;
  endsequence

  a_cpu_flag_set: assert property (
    tick && !r.s2[pmc_pkg::PMC_SY_VG] && !cpu_core_volt_good_exempt |=> r.cpu_flr)
    else $error("cpu power fail flag not set");
  a_cpu_flag_exempt: assert property (
    !r.cpu_flr && (cpu_core_volt_good_exempt || r.s2[pmc_pkg::PMC_SY_VG]) |=> !r.cpu_flr)
    else $error("cpu power fail flag set during exempt window");
  a_cpu_flag_clear: assert property (
    wr_flr && !cfg_wdata[pmc_pkg::PMC_FLR_CPU] && !(tick && !r.s2[pmc_pkg::PMC_SY_VG])
    |=> !r.cpu_flr)
    else $error("cpu power fail flag not cleared by zero write");
  a_main_power_good_flag_set: assert property (
    pg_fall && sys_state == pmc_pkg::PMC_SYS_S0 |=> r.power_good_fail_flag)
    else $error("power good fail flag not set");
  a_main_power_good_flag_hold: assert property (
    r.power_good_fail_flag && !(wr_flr && cfg_wdata[pmc_pkg::PMC_FLR_MAIN_POWER_GOOD])
    && sys_state != pmc_pkg::PMC_SYS_G3 |=> r.power_good_fail_flag)
    else $error("power good fail flag lost without clear");
  a_resume_reboot: assert property (
    s_drop_return |=> s_one_pulse)
    else $error("resume reboot pulse missing");
  a_full_return: assert property (
    r.pl == pmc_pkg::PMC_PL_FULL && r.s2[pmc_pkg::PMC_SY_PG] && r.rs_rtc && !r.policy
    |=> r.pwr_ret && r.ret_state == pmc_pkg::PMC_SYS_S0 ##1 !r.pwr_ret)
    else $error("power return to S0 missing");
  a_stop_held: assert property (
    r.sc != pmc_pkg::PMC_SC_RUN |-> !r.stop_n)
    else $error("stop clock released early");
  a_route_smi: assert property (
    input_event_status[0] && gpio_is_input[0] && r.route[1:0] == pmc_pkg::PMC_ROUTE_SMI
    && alternate_input_smi_enable[0] |=> r.smi[0] ##1 (!r.smi[0] || $past(input_event_status[0])))
    else $error("input smi routing missing");
  a_batt_status: assert property (
    tick && !r.s2[pmc_pkg::PMC_SY_BR] |=> r.batt_rm && !r.policy)
    else $error("battery status not set");
endmodule

// ---- design/pmc_pkg.sv ----
// constants and enumerations for the power management configuration block
// assumes one 25 MHz core clock; the battery-well clock appears only as a tick
package pmc_pkg;
  // register byte offsets
  localparam logic [7:0]  PMC_OFS_FLR   = 8'hA0;
  localparam logic [7:0]  PMC_OFS_CFG3  = 8'hA4;
  localparam logic [7:0]  PMC_OFS_STOP  = 8'hA8;
  localparam logic [7:0]  PMC_OFS_ROUTE = 8'hB8;
  // reset values
  localparam logic [1:0]  PMC_RATE_RST  = 2'h0;
  localparam logic [5:0]  PMC_STOP_RST  = 6'h0D;
  localparam logic [31:0] PMC_ROUTE_RST = 32'h0000_0000;
  // field positions
  localparam int PMC_FLR_MAIN_POWER_GOOD   = 0;
  localparam int PMC_FLR_CPU     = 1;
  localparam int PMC_CFG3_POLICY = 0;
  localparam int PMC_CFG3_TRICKLE = 1;
  localparam int PMC_CFG3_BATT   = 2;
  localparam int PMC_CFG3_RATE   = 6;
  // route codes
  localparam logic [1:0]  PMC_ROUTE_SMI = 2'h1;
  localparam logic [1:0]  PMC_ROUTE_SCI = 2'h2;
  // system sleep state codes
  localparam logic [2:0]  PMC_SYS_S0  = 3'h0;
  localparam logic [2:0]  PMC_SYS_S1M = 3'h1;
  localparam logic [2:0]  PMC_SYS_S4  = 3'h4;
  localparam logic [2:0]  PMC_SYS_S5  = 3'h5;
  localparam logic [2:0]  PMC_SYS_G3  = 3'h7;
  // synchroniser bit positions
  localparam int PMC_SY_VG = 0;
  localparam int PMC_SY_PG = 1;
  localparam int PMC_SY_RS = 2;
  localparam int PMC_SY_BR = 3;
  localparam int PMC_SY_TF = 4;
  localparam int PMC_SY_SL = 5;
  // timing
  localparam int PMC_CLK_KHZ      = 25000;
  localparam int PMC_RTC_PER_NS   = 30518;
  localparam int PMC_RTC_DIV_CYC  = PMC_RTC_PER_NS * PMC_CLK_KHZ / 1000000;
  localparam int PMC_STEP_NS      = 3850;
  localparam int PMC_STEP_CYC     = PMC_STEP_NS * PMC_CLK_KHZ / 1000000;
  localparam int PMC_SW_BASE_US   = 500;
  localparam int PMC_SW_BASE_CYC  = PMC_SW_BASE_US * PMC_CLK_KHZ / 1000;
  // software timer periods in base units of 0.5 ms
  localparam logic [7:0]  PMC_SW_CNT0 = 8'h03;
  localparam logic [7:0]  PMC_SW_CNT1 = 8'h20;
  localparam logic [7:0]  PMC_SW_CNT2 = 8'h40;
  localparam logic [7:0]  PMC_SW_CNT3 = 8'h80;
  // power loss tracker and stop clock states
  typedef enum logic [2:0] {
    PMC_PL_IDLE = 3'b001,
    PMC_PL_DOWN = 3'b010,
    PMC_PL_FULL = 3'b100
  } pmc_pl_t;
  typedef enum logic [2:0] {
    PMC_SC_RUN  = 3'b001,
    PMC_SC_STOP = 3'b010,
    PMC_SC_WAIT = 3'b100
  } pmc_sc_t;
endpackage

// ---- verif/pmc_supply_model.sv ----
// model of the processor, its voltage regulator and the system supply
// assumes tasks are called just after a rising clock edge of clk_sys
`timescale 1ns/1ps
module pmc_supply_model (
  input  wire logic clk_sys,
  input  wire logic proc_stop_clock_n,
  output logic      cpu_core_volt_good,
  output logic      main_power_good,
  output logic      resume_well_reset_n,
  output logic      battery_well_reset_n,
  output logic      trickle_supply_ok,
  output logic      proc_sleep_n
);
  // all supplies good and processor awake at power-up
  initial begin
    cpu_core_volt_good   = 1'h1;
    main_power_good      = 1'h1;
    resume_well_reset_n  = 1'h1;
    battery_well_reset_n = 1'h1;
    trickle_supply_ok    = 1'h1;
    proc_sleep_n         = 1'h1;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic volt_dip(input int n);
    cpu_core_volt_good = 1'h0;
    wait_cyc(n);
    cpu_core_volt_good = 1'h1;
  endtask
  // short supply drop, resume reset stays high
  task automatic power_blip(input int n);
    main_power_good = 1'h0;
    wait_cyc(n);
    main_power_good = 1'h1;
  endtask
  // resume reset low past an rtc period
  task automatic full_loss();
    main_power_good = 1'h0;
    wait_cyc(3);
    resume_well_reset_n = 1'h0;
    wait_cyc(12);
    resume_well_reset_n = 1'h1;
    wait_cyc(12);
    main_power_good = 1'h1;
  endtask
  // battery well reset and trickle supply failure
  task automatic battery_reset(input int n);
    battery_well_reset_n = 1'h0;
    wait_cyc(n);
    battery_well_reset_n = 1'h1;
  endtask
  task automatic trickle_dip(input int n);
    trickle_supply_ok = 1'h0;
    wait_cyc(n);
    trickle_supply_ok = 1'h1;
  endtask
  // processor sleeps once stop clock is granted and wakes after n cycles
  task automatic sleep_cycle(input int n);
    while (proc_stop_clock_n !== 1'h0) wait_cyc(1);
    proc_sleep_n = 1'h0;
    wait_cyc(n);
    proc_sleep_n = 1'h1;
  endtask
endmodule

// ---- verif/power_mgmt_config_regs_bench.sv ----
// self-checking bench for the power management configuration registers
// assumes the package, the design and the supply model are compiled first
`timescale 1ns/1ps
module power_mgmt_config_regs_bench;
  logic        clk_sys, resetn, cfg_wr, cfg_rd, cpu_core_volt_good_exempt, reset_ctl_write;
  logic        stop_clock_req, sw_timer_start;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [2:0]  sys_state, power_return_state, ret_state;
  logic [15:0] input_event_status, gpio_is_input, general_event_enable;
  logic [15:0] alternate_input_smi_enable, input_smi_req, input_sci_req, input_wake_req;
  logic [15:0] smi_seen, sci_seen, wake_seen;
  logic        proc_stop_clock_n, sw_timer_timeout, resume_reboot, power_return;
  logic        after_power_loss_policy;
  logic        mon_clr;
  wire         cpu_core_volt_good, main_power_good, resume_well_reset_n;
  wire         battery_well_reset_n, trickle_supply_ok, proc_sleep_n;
  int          fail_count, n_compared, cyc, reboot_cnt, return_cnt, k;
  int          lim [4] = '{3, 32, 64, 128};
  logic [5:0]  dly [2] = '{6'h02, 6'h3F};
  pmc_power_mgmt_regs #(.GPI_IMPL(16'h7FFF), .RTC_DIV(4), .STEP_CYC(2), .SWSMI_BASE(4)) DUT (
    .clk_sys                    (clk_sys),
    .resetn                     (resetn),
    .cfg_addr                   (cfg_addr),
    .cfg_be                     (cfg_be),
    .cfg_wr                     (cfg_wr),
    .cfg_rd                     (cfg_rd),
    .cfg_wdata                  (cfg_wdata),
    .cfg_rdata                  (cfg_rdata),
    .cpu_core_volt_good         (cpu_core_volt_good),
    .main_power_good            (main_power_good),
    .resume_well_reset_n        (resume_well_reset_n),
    .battery_well_reset_n       (battery_well_reset_n),
    .trickle_supply_ok          (trickle_supply_ok),
    .proc_sleep_n               (proc_sleep_n),
    .cpu_core_volt_good_exempt               (cpu_core_volt_good_exempt),
    .sys_state                  (sys_state),
    .reset_ctl_write            (reset_ctl_write),
    .stop_clock_req             (stop_clock_req),
    .sw_timer_start             (sw_timer_start),
    .input_event_status         (input_event_status),
    .gpio_is_input              (gpio_is_input),
    .general_event_enable       (general_event_enable),
    .alternate_input_smi_enable (alternate_input_smi_enable),
    .proc_stop_clock_n          (proc_stop_clock_n),
    .sw_timer_timeout           (sw_timer_timeout),
    .resume_reboot              (resume_reboot),
    .power_return               (power_return),
    .power_return_state         (power_return_state),
    .after_power_loss_policy    (after_power_loss_policy),
    .input_smi_req              (input_smi_req),
    .input_sci_req              (input_sci_req),
    .input_wake_req             (input_wake_req)
  );
  pmc_supply_model u_far (
    .clk_sys              (clk_sys),
    .proc_stop_clock_n    (proc_stop_clock_n),
    .cpu_core_volt_good   (cpu_core_volt_good),
    .main_power_good      (main_power_good),
    .resume_well_reset_n  (resume_well_reset_n),
    .battery_well_reset_n (battery_well_reset_n),
    .trickle_supply_ok    (trickle_supply_ok),
    .proc_sleep_n         (proc_sleep_n)
  );
  // clock of 40 ns period
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  // pulse monitor, emptied while mon_clr is high, and hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (mon_clr) begin
      smi_seen <= 16'h0000;
      sci_seen <= 16'h0000;
      wake_seen <= 16'h0000;
      reboot_cnt <= 0;
      return_cnt <= 0;
      ret_state <= 3'h0;
    end else begin
      smi_seen <= smi_seen | input_smi_req;
      sci_seen <= sci_seen | input_sci_req;
      wake_seen <= wake_seen | input_wake_req;
      if (resume_reboot === 1'h1) reboot_cnt <= reboot_cnt + 1;
      if (power_return === 1'h1) begin
        return_cnt <= return_cnt + 1;
        ret_state <= power_return_state;
      end
    end
    if (cyc == 20000) begin
      $display("timeout after %0d cycles", cyc);
      end_of_test(1'b1);
    end
  end
  // a timeout counts as one more mismatch
  task automatic end_of_test(input bit late);
    int fails;
    fails = fail_count + int'(late);
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic clr();
    mon_clr = 1'h1;
    tick(1);
    mon_clr = 1'h0;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'h1;
    tick(1);
    cfg_wr = 1'h0;
    tick(1);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    cfg_addr = a;
    cfg_rd = 1'h1;
    tick(1);
    cfg_rd = 1'h0;
    check(what, cfg_rdata, exp);
    tick(1);
  endtask
  // one status pulse, then the three request kinds
  task automatic pulse_gpi(input logic [15:0] st, input logic [15:0] es, ec, ew);
    clr();
    input_event_status = st;
    tick(1);
    input_event_status = 16'h0000;
    tick(2);
    check("smi req", 32'(smi_seen), 32'(es));
    check("sci req", 32'(sci_seen), 32'(ec));
    check("wake req", 32'(wake_seen), 32'(ew));
  endtask
  initial begin
    {cfg_wr, cfg_rd, cpu_core_volt_good_exempt, reset_ctl_write, stop_clock_req, sw_timer_start} = '0;
    {cfg_addr, cfg_wdata, input_event_status} = '0;
    cfg_be = 4'hF;
    sys_state = 3'h0;
    {gpio_is_input, general_event_enable, alternate_input_smi_enable} = '1;
    {fail_count, n_compared} = '0;
    mon_clr = 1'h1;
    resetn = 1'h0;
    tick(5);
    resetn = 1'h1;
    rd_chk("delay reset", 8'hA8, 32'h0000_000D);
    rd_chk("route reset", 8'hB8, 32'h0000_0000);
    rd_chk("unmapped", 8'h10, 32'h0000_0000);
    reg_wr(8'hB8, 32'hFFFF_FFFF);
    rd_chk("absent route", 8'hB8, 32'h3FFF_FFFF);
    cfg_be = 4'h2;
    reg_wr(8'hB8, 32'h0000_0000);
    cfg_be = 4'hE;
    reg_wr(8'hA8, 32'h0000_0005);
    cfg_be = 4'hF;
    rd_chk("route lane one", 8'hB8, 32'h3FFF_00FF);
    rd_chk("delay lane zero", 8'hA8, 32'h0000_000D);
    $display("test registers done");
    reg_wr(8'hB8, 32'h0000_08E4);
    pulse_gpi(16'h002F, 16'h0002, 16'h0024, 16'h0000);
    gpio_is_input = 16'hFFDD;
    pulse_gpi(16'h0022, 16'h0000, 16'h0000, 16'h0000);
    {gpio_is_input, alternate_input_smi_enable, general_event_enable} = {16'hFFFF, 16'hFFFD, 16'hFFDF};
    pulse_gpi(16'h0022, 16'h0000, 16'h0000, 16'h0000);
    {alternate_input_smi_enable, general_event_enable, sys_state} = {16'hFFFF, 16'hFFFF, 3'h4};
    pulse_gpi(16'h0001, 16'h0000, 16'h0000, 16'h0001);
    pulse_gpi(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    sys_state = 3'h0;
    reg_wr(8'hB8, 32'h0000_0001);
    pulse_gpi(16'h0001, 16'h0001, 16'h0000, 16'h0000);
    $display("test routing done");
    for (int r = 0; r < 4; r++) begin
      reg_wr(8'hA4, 32'(r) << 6);
      sw_timer_start = 1'h1;
      tick(1);
      sw_timer_start = 1'h0;
      for (k = 1; k < 1000 && sw_timer_timeout !== 1'h1; k++) tick(1);
      check("timer period", 32'(k >= lim[r] * 4 - 1 && k <= lim[r] * 4 + 2), 32'h1);
    end
    $display("test software timer done");
    for (int i = 0; i < 2; i++) begin
      reg_wr(8'hA8, 32'(dly[i]));
      stop_clock_req = 1'h1;
      tick(2);
      check("stop asserted", 32'(proc_stop_clock_n), 32'h0);
      stop_clock_req = 1'h0;
      u_far.sleep_cycle(6);
      for (k = 1; k < 400 && proc_stop_clock_n !== 1'h1; k++) tick(1);
      check("stop delay", 32'(k >= dly[i] * 2 + 1 && k <= dly[i] * 2 + 5), 32'h1);
    end
    $display("test stop clock done");
    u_far.volt_dip(12);
    tick(4);
    rd_chk("cpu flag set", 8'hA0, 32'h0000_0002);
    reg_wr(8'hA0, 32'h0000_0002);
    rd_chk("cpu flag kept", 8'hA0, 32'h0000_0002);
    reg_wr(8'hA0, 32'h0000_0000);
    rd_chk("cpu flag clear", 8'hA0, 32'h0000_0000);
    cpu_core_volt_good_exempt = 1'h1;
    u_far.volt_dip(12);
    tick(4);
    cpu_core_volt_good_exempt = 1'h0;
    rd_chk("cpu flag exempt", 8'hA0, 32'h0000_0000);
    $display("test cpu flag done");
    clr();
    u_far.power_blip(6);
    tick(6);
    check("reboot", 32'(reboot_cnt), 32'h1);
    check("no return", 32'(return_cnt), 32'h0);
    rd_chk("pg flag set", 8'hA0, 32'h0000_0001);
    reg_wr(8'hA0, 32'h0000_0000);
    rd_chk("pg flag kept", 8'hA0, 32'h0000_0001);
    reg_wr(8'hA0, 32'h0000_0001);
    rd_chk("pg flag w1c", 8'hA0, 32'h0000_0000);
    u_far.power_blip(6);
    tick(6);
    sys_state = 3'h7;
    tick(3);
    sys_state = 3'h4;
    rd_chk("pg flag g3", 8'hA0, 32'h0000_0000);
    u_far.power_blip(6);
    tick(6);
    rd_chk("pg flag asleep", 8'hA0, 32'h0000_0000);
    sys_state = 3'h1;
    u_far.power_blip(6);
    tick(6);
    sys_state = 3'h0;
    rd_chk("pg flag s1m", 8'hA0, 32'h0000_0001);
    reg_wr(8'hA0, 32'h0000_0001);
    $display("test power good done");
    for (int i = 0; i < 3; i++) begin
      reg_wr(8'hA4, (i < 2) ? 32'h1 : 32'h0);
      sys_state = (i == 1) ? 3'h5 : 3'h4;
      clr();
      u_far.full_loss();
      tick(12);
      check("return", 32'(return_cnt), 32'h1);
      check("no reboot", 32'(reboot_cnt), 32'h0);
      check("return state", 32'(ret_state), (i < 2) ? 32'(sys_state) : 32'h0);
    end
    sys_state = 3'h0;
    $display("test power loss done");
    reg_wr(8'hA4, 32'h0000_0001);
    check("policy set", 32'(after_power_loss_policy), 32'h1);
    reset_ctl_write = 1'h1;
    tick(1);
    reset_ctl_write = 1'h0;
    tick(1);
    check("policy ctl", 32'(after_power_loss_policy), 32'h0);
    reg_wr(8'hA4, 32'h0000_0001);
    u_far.battery_reset(12);
    tick(4);
    rd_chk("battery removed", 8'hA4, 32'h0000_0004);
    u_far.trickle_dip(6);
    tick(4);
    rd_chk("trickle set", 8'hA4, 32'h0000_0006);
    reg_wr(8'hA4, 32'h0000_0006);
    rd_chk("trickle w1c", 8'hA4, 32'h0000_0004);
    $display("test battery well done");
    end_of_test(1'b0);
  end
endmodule
